/* File: hw/cpm_pkg.sv */
// Constants and types for the CPU-interface priority mask and running priority block.
// Behaviour
// R01: Forward interrupt only if priority beats mask.
// R02: Mask write acts immediately, no barrier.
// R03: Mask is 64 bits, upper 56 zero.
// R04: Implemented priority bits set mask granularity.
// R05: Unimplemented low mask bits read zero, ignore writes.
// R06: Warm reset clears mask to zero.
// R07: Mask reads and writes use one encoding.
// R08: Lowest privilege access is undefined.
// R09: EL1 with interface disabled traps to EL1.
// R10: Common register trap bit sends EL1 to EL2.
// R11: Routing overrides redirect EL1 to virtual copies.
// R12: Secure routing both set traps to EL3.
// R13: EL2 with interface disabled traps to EL2.
// R14: EL3 disabled traps, else physical access.
// R15: Running priority is read-only active group priority.
// R16: No active interrupt reads idle priority.
// R17: Group priority uses minimum binary point.
// R18: Running priority encoding; hides implemented bit count.
// R19: Compare only implemented bits, low bits zero.
package cpm_pkg;

   // ****************************************************************
   // Widths.
   // ****************************************************************
   localparam int PRIO_W = 8;
   localparam int DATA_W = 64;
   localparam int RSVD_W = DATA_W - PRIO_W;
   localparam int CLASS_W = 6;

   // ****************************************************************
   // Access encodings and levels.
   // ****************************************************************
   localparam logic [1:0] SYS_OP0 = 2'h3;
   localparam logic [2:0] SYS_OP1 = 3'h0;
   localparam logic [3:0] PMR_CRN = 4'h4;
   localparam logic [3:0] PMR_CRM = 4'h6;
   localparam logic [2:0] PMR_OP2 = 3'h0;
   localparam logic [3:0] RPR_CRN = 4'hc;
   localparam logic [3:0] RPR_CRM = 4'hb;
   localparam logic [2:0] RPR_OP2 = 3'h3;
   localparam logic [1:0] LVL_EL0 = 2'h0;
   localparam logic [1:0] LVL_EL1 = 2'h1;
   localparam logic [1:0] LVL_EL2 = 2'h2;
   localparam logic [1:0] LVL_EL3 = 2'h3;

   // ****************************************************************
   // Values.
   // ****************************************************************
   localparam logic [CLASS_W-1:0] TRAP_CLASS = 6'h18;
   localparam logic [CLASS_W-1:0] NO_CLASS = 6'h00;
   localparam logic [PRIO_W-1:0] MASK_RESET = 8'h00;
   localparam logic [PRIO_W-1:0] IDLE_PRIO = 8'hff;
   localparam logic [PRIO_W-1:0] FULL_BITS = 8'hff;
   localparam logic [PRIO_W-1:0] GROUP_MIN_MASK = 8'hfe;
   localparam logic [RSVD_W-1:0] RSVD_ZERO = 56'h00_0000_0000_0000;

   typedef enum logic [1:0] {
      CPM_RES_PHYS = 2'b00,
      CPM_RES_VIRT = 2'b01,
      CPM_RES_UNDEF = 2'b10,
      CPM_RES_TRAP = 2'b11
   } cpm_result_t;

endpackage

/* File: hw/cpm_access_check.sv */
// Privilege and configuration check that routes one register access.
`timescale 1ns/1ps
module cpm_access_check
   import cpm_pkg::*;
#(
   parameter logic EL3_TRAP_PRIO = 1'b1
) (
   input wire logic [1:0] el,
   input wire logic sre_el1,
   input wire logic sre_el2,
   input wire logic sre_el3,
   input wire logic el2_enabled,
   input wire logic el3_present,
   input wire logic common_reg_trap,
   input wire logic fiq_route_override,
   input wire logic irq_route_override,
   input wire logic secure_irq_route,
   input wire logic secure_fiq_route,
   input wire logic halted,
   input wire logic secure_debug_disable,
   output cpm_result_t result,
   output logic [1:0] target_el
);

   logic scr_both;
   logic early_undef;
   logic el3_route;
   logic dbg_undef;

   assign scr_both = secure_irq_route & secure_fiq_route;
   assign el3_route = el3_present & scr_both;
   assign dbg_undef = halted & secure_debug_disable;
   assign early_undef = dbg_undef & el3_route & EL3_TRAP_PRIO;

   // ****************************************************************
   // Decision by level, first match wins.
   // ****************************************************************
   always_comb begin
      result = CPM_RES_UNDEF;
      target_el = el;
      case (el)
         LVL_EL0: begin
            result = CPM_RES_UNDEF; // [R08]
         end
         LVL_EL1: begin
            if (early_undef) begin
               result = CPM_RES_UNDEF; // [R12]
            end else if (!sre_el1) begin
               result = CPM_RES_TRAP; // [R09]
               target_el = LVL_EL1;
            end else if (el2_enabled && common_reg_trap) begin
               result = CPM_RES_TRAP; // [R10]
               target_el = LVL_EL2;
            end else if (el2_enabled && (fiq_route_override || irq_route_override)) begin
               result = CPM_RES_VIRT; // [R11]
            end else if (el3_route) begin
               result = dbg_undef ? CPM_RES_UNDEF : CPM_RES_TRAP; // [R12]
               target_el = LVL_EL3;
            end else begin
               result = CPM_RES_PHYS;
            end
         end
         LVL_EL2: begin
            if (early_undef) begin
               result = CPM_RES_UNDEF; // [R12]
            end else if (!sre_el2) begin
               result = CPM_RES_TRAP; // [R13]
               target_el = LVL_EL2;
            end else if (el3_route) begin
               result = dbg_undef ? CPM_RES_UNDEF : CPM_RES_TRAP; // [R12]
               target_el = LVL_EL3;
            end else begin
               result = CPM_RES_PHYS;
            end
         end
         LVL_EL3: begin
            if (!sre_el3) begin
               result = CPM_RES_TRAP; // [R14]
               target_el = LVL_EL3;
            end else begin
               result = CPM_RES_PHYS; // [R14]
            end
         end
         default: begin
            result = CPM_RES_UNDEF;
         end
      endcase
   end

endmodule

/* File: hw/cpm_cpu_prio.sv */
// Priority mask and running priority registers with interrupt forwarding filter.
`timescale 1ns/1ps
module cpm_cpu_prio
   import cpm_pkg::*;
#(
   parameter int PRIO_BITS = 8,
   parameter logic EL3_TRAP_PRIO = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [1:0] req_el,
   input wire logic [1:0] req_op0,
   input wire logic [2:0] req_op1,
   input wire logic [3:0] req_crn,
   input wire logic [3:0] req_crm,
   input wire logic [2:0] req_op2,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic sre_el1,
   input wire logic sre_el2,
   input wire logic sre_el3,
   input wire logic el2_enabled,
   input wire logic el3_present,
   input wire logic common_reg_trap,
   input wire logic fiq_route_override,
   input wire logic irq_route_override,
   input wire logic secure_irq_route,
   input wire logic secure_fiq_route,
   input wire logic halted,
   input wire logic secure_debug_disable,
   input wire logic pend_valid,
   input wire logic [PRIO_W-1:0] pend_priority,
   input wire logic active_valid,
   input wire logic [PRIO_W-1:0] active_priority,
   input wire logic [PRIO_W-1:0] virtual_running_priority,
   output logic resp_valid,
   output cpm_result_t resp_result,
   output logic [1:0] resp_target_el,
   output logic [CLASS_W-1:0] resp_class,
   output logic [DATA_W-1:0] resp_rdata,
   output logic irq_forward,
   output logic [PRIO_W-1:0] priority_mask,
   output logic [PRIO_W-1:0] virtual_priority_mask
);

   // ****************************************************************
   // Granularity masks.
   // ****************************************************************
   localparam logic [PRIO_W-1:0] IMPL_MASK = PRIO_W'(FULL_BITS << (PRIO_W - PRIO_BITS));
   localparam logic [PRIO_W-1:0] GROUP_MASK = IMPL_MASK & GROUP_MIN_MASK;

   logic hit_pmr;
   logic hit_rpr;
   logic hit_any;
   cpm_result_t chk_result;
   logic [1:0] chk_target;
   cpm_result_t next_result;
   logic phys_wr;
   logic virt_wr;
   logic [PRIO_W-1:0] wr_level;
   logic [PRIO_W-1:0] next_mask;
   logic [PRIO_W-1:0] next_vmask;
   logic [PRIO_W-1:0] pend_level;
   logic fwd_cond;
   logic [PRIO_W-1:0] running_priority;
   logic [PRIO_W-1:0] next_running;
   logic [PRIO_W-1:0] rd_level;

   // ****************************************************************
   // Encoding decode.
   // ****************************************************************
   assign hit_pmr = (req_op0 == SYS_OP0) && (req_op1 == SYS_OP1) && (req_crn == PMR_CRN)
      && (req_crm == PMR_CRM) && (req_op2 == PMR_OP2); // [R07]
   assign hit_rpr = (req_op0 == SYS_OP0) && (req_op1 == SYS_OP1) && (req_crn == RPR_CRN)
      && (req_crm == RPR_CRM) && (req_op2 == RPR_OP2) && !req_write; // [R15] [R18]
   assign hit_any = hit_pmr || hit_rpr;

   cpm_access_check #(
      .EL3_TRAP_PRIO(EL3_TRAP_PRIO)
   ) u_check (
      .el(req_el),
      .sre_el1(sre_el1),
      .sre_el2(sre_el2),
      .sre_el3(sre_el3),
      .el2_enabled(el2_enabled),
      .el3_present(el3_present),
      .common_reg_trap(common_reg_trap),
      .fiq_route_override(fiq_route_override),
      .irq_route_override(irq_route_override),
      .secure_irq_route(secure_irq_route),
      .secure_fiq_route(secure_fiq_route),
      .halted(halted),
      .secure_debug_disable(secure_debug_disable),
      .result(chk_result),
      .target_el(chk_target)
   );

   assign next_result = hit_any ? chk_result : CPM_RES_UNDEF;

   // ****************************************************************
   // Mask registers.
   // ****************************************************************
   assign wr_level = req_wdata[PRIO_W-1:0] & IMPL_MASK; // [R03] [R04] [R05]
   assign phys_wr = req_valid && req_write && hit_pmr && (chk_result == CPM_RES_PHYS);
   assign virt_wr = req_valid && req_write && hit_pmr && (chk_result == CPM_RES_VIRT);
   assign next_mask = phys_wr ? wr_level : priority_mask;
   assign next_vmask = virt_wr ? wr_level : virtual_priority_mask; // [R11]

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         priority_mask <= MASK_RESET; // [R06]
      end else begin
         priority_mask <= next_mask;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         virtual_priority_mask <= MASK_RESET;
      end else begin
         virtual_priority_mask <= next_vmask;
      end
   end

   // ****************************************************************
   // Interrupt forwarding filter.
   // ****************************************************************
   assign pend_level = pend_priority & IMPL_MASK; // [R19]
   assign fwd_cond = pend_valid && (pend_level < next_mask); // [R01] [R02]

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_forward <= 1'b0;
      end else begin
         irq_forward <= fwd_cond;
      end
   end

   // ****************************************************************
   // Running priority.
   // ****************************************************************
   assign next_running = active_valid ? (active_priority & GROUP_MASK) : IDLE_PRIO; // [R16] [R17] [R19]

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         running_priority <= IDLE_PRIO;
      end else begin
         running_priority <= next_running;
      end
   end

   // ****************************************************************
   // Read data selection.
   // ****************************************************************
   always_comb begin
      rd_level = MASK_RESET;
      if (hit_pmr) begin
         rd_level = (chk_result == CPM_RES_VIRT) ? virtual_priority_mask : priority_mask;
      end else if (hit_rpr) begin
         rd_level = (chk_result == CPM_RES_VIRT) ? virtual_running_priority : running_priority; // [R15]
      end
   end

   // ****************************************************************
   // Response registers.
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resp_valid <= 1'b0;
      end else begin
         resp_valid <= req_valid;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resp_result <= CPM_RES_UNDEF;
         resp_target_el <= LVL_EL0;
         resp_class <= NO_CLASS;
      end else if (req_valid) begin
         resp_result <= next_result;
         resp_target_el <= (next_result == CPM_RES_TRAP) ? chk_target : req_el;
         resp_class <= (next_result == CPM_RES_TRAP) ? TRAP_CLASS : NO_CLASS;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resp_rdata <= {RSVD_ZERO, MASK_RESET};
      end else if (req_valid) begin
         if (!req_write && (next_result == CPM_RES_PHYS || next_result == CPM_RES_VIRT)) begin
            resp_rdata <= {RSVD_ZERO, rd_level}; // [R03]
         end else begin
            resp_rdata <= {RSVD_ZERO, MASK_RESET};
         end
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking

   default disable iff (sys_rst);

   chk_forward_filter: assert property ( // [R01]
      !$past(sys_rst) |-> irq_forward == $past(pend_valid && ((pend_priority & IMPL_MASK) < next_mask))
   ) else $error("forward output disagrees with mask comparison");

   chk_mask_now: assert property ( // [R02]
      phys_wr |=> priority_mask == $past(wr_level) ##0 (irq_forward == $past(fwd_cond))
   ) else $error("mask write not effective in next cycle");

   chk_rsvd_zero: assert property ( // [R03]
      resp_valid |-> resp_rdata[DATA_W-1:PRIO_W] == RSVD_ZERO
   ) else $error("reserved read bits not zero");

   chk_low_bits: assert property ( // [R05]
      ((priority_mask & ~IMPL_MASK) == MASK_RESET)
      && (((running_priority & ~GROUP_MASK) == MASK_RESET) || (running_priority == IDLE_PRIO))
   ) else $error("unimplemented mask bits set");

   chk_el0_undef: assert property ( // [R08]
      req_valid && req_el == LVL_EL0 |=> resp_valid && resp_result == CPM_RES_UNDEF && resp_class == NO_CLASS
   ) else $error("lowest level access not undefined");

   chk_sre1_trap: assert property ( // [R09]
      req_valid && hit_any && req_el == LVL_EL1 && !sre_el1 && !(halted && secure_debug_disable && el3_present)
      |=> resp_result == CPM_RES_TRAP && resp_target_el == LVL_EL1 && resp_class == TRAP_CLASS
   ) else $error("disabled interface at EL1 did not trap to EL1");

   chk_tc_trap: assert property ( // [R10]
      req_valid && hit_any && req_el == LVL_EL1 && sre_el1 && el2_enabled && common_reg_trap
      && !(halted && secure_debug_disable && el3_present)
      |=> resp_result == CPM_RES_TRAP && resp_target_el == LVL_EL2
   ) else $error("common register trap did not reach EL2");

   chk_virt_route: assert property ( // [R11]
      req_valid && req_write && hit_pmr && chk_result == CPM_RES_VIRT
      |=> virtual_priority_mask == $past(wr_level) && $stable(priority_mask)
   ) else $error("virtual write touched the physical mask");

   chk_sre2_trap: assert property ( // [R13]
      req_valid && hit_any && req_el == LVL_EL2 && !sre_el2 && !(halted && secure_debug_disable && el3_present)
      |=> resp_result == CPM_RES_TRAP && resp_target_el == LVL_EL2
   ) else $error("disabled interface at EL2 did not trap to EL2");

   chk_sre3_path: assert property ( // [R14]
      req_valid && hit_any && req_el == LVL_EL3
      |=> resp_result == ($past(sre_el3) ? CPM_RES_PHYS : CPM_RES_TRAP)
   ) else $error("EL3 access outcome wrong");

   chk_rpr_idle: assert property ( // [R16]
      !active_valid [*2] ##0 req_valid && hit_rpr && chk_result == CPM_RES_PHYS |=> resp_rdata[PRIO_W-1:0] == IDLE_PRIO
   ) else $error("idle running priority not reported");

   chk_rpr_group: assert property ( // [R17]
      active_valid && !sys_rst |=> running_priority == ($past(active_priority) & GROUP_MASK)
   ) else $error("running priority not group priority");

   chk_rst_mask: assert property ( // [R06]
      $past(sys_rst) |-> priority_mask == MASK_RESET
   ) else $error("mask not cleared by reset");

   chk_enc_write: assert property ( // [R07]
      req_valid && req_write && req_el == LVL_EL3 && sre_el3
      && req_op0 == SYS_OP0 && req_op1 == SYS_OP1 && req_crn == PMR_CRN
      && req_crm == PMR_CRM && req_op2 == PMR_OP2
      |=> priority_mask == ($past(req_wdata[PRIO_W-1:0]) & IMPL_MASK)
   ) else $error("mask write lost");

   chk_el3_route: assert property ( // [R12]
      req_valid && hit_any && req_el == LVL_EL2 && sre_el2 && el3_present
      && secure_irq_route && secure_fiq_route && !halted
      |=> resp_result == CPM_RES_TRAP && resp_target_el == LVL_EL3
      && resp_class == TRAP_CLASS
   ) else $error("no trap to EL3");

   chk_run_ro: assert property ( // [R15]
      req_valid && req_write && req_crn == RPR_CRN
      && req_crm == RPR_CRM && req_op2 == RPR_OP2
      |=> resp_result == CPM_RES_UNDEF && $stable(priority_mask)
   ) else $error("running priority took a write");

   chk_equal_level: assert property ( // [R04]
      pend_valid && !req_valid && (pend_priority & IMPL_MASK) == priority_mask |=> !irq_forward
   ) else $error("equal level passed");

   chk_run_reset: assert property ( // [R16]
      $past(sys_rst) |-> running_priority == IDLE_PRIO
   ) else $error("running priority not idle");

   chk_write_rdata: assert property ( // [R03]
      req_valid && req_write |=> resp_rdata == {RSVD_ZERO, MASK_RESET}
   ) else $error("write returned data");

   chk_virt_read: assert property ( // [R11]
      req_valid && !req_write && hit_rpr && chk_result == CPM_RES_VIRT
      |=> resp_rdata[PRIO_W-1:0] == $past(virtual_running_priority)
   ) else $error("virtual running priority lost");

endmodule

/* File: bench/cpm_core_model.sv */
// Processor core model that issues system register accesses to the priority block.
`timescale 1ns/1ps
module cpm_core_model
   import cpm_pkg::*;
(
   input wire logic clk,
   input wire logic resp_valid,
   input wire cpm_result_t resp_result,
   input wire logic [1:0] resp_target_el,
   input wire logic [CLASS_W-1:0] resp_class,
   input wire logic [DATA_W-1:0] resp_rdata,
   output logic req_valid,
   output logic req_write,
   output logic [1:0] req_el,
   output logic [1:0] req_op0,
   output logic [2:0] req_op1,
   output logic [3:0] req_crn,
   output logic [3:0] req_crm,
   output logic [2:0] req_op2,
   output logic [DATA_W-1:0] req_wdata
);

   // ****************************************************************
   // Idle request lines.
   // ****************************************************************
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_el = 2'h0;
      req_op0 = 2'h0;
      req_op1 = 3'h0;
      req_crn = 4'h0;
      req_crm = 4'h0;
      req_op2 = 3'h0;
      req_wdata = 64'h0000_0000_0000_0000;
   end

   // ****************************************************************
   // One access: a one-cycle request, then the response is collected.
   // ****************************************************************
   task automatic access(input logic wr, input logic [1:0] el, input logic [3:0] crn, input logic [3:0] crm,
                         input logic [2:0] op2, input logic [DATA_W-1:0] wd, output cpm_result_t res,
                         output logic [1:0] tgt, output logic [CLASS_W-1:0] cls, output logic [DATA_W-1:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_el <= el;
      req_op0 <= SYS_OP0;
      req_op1 <= SYS_OP1;
      req_crn <= crn;
      req_crm <= crm;
      req_op2 <= op2;
      req_wdata <= wd;
      @(posedge clk);
      req_valid <= 1'b0;
      req_wdata <= ~wd;
      req_crn <= ~crn;
      #1;
      while (resp_valid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      res = resp_result;
      tgt = resp_target_el;
      cls = resp_class;
      rd = resp_rdata;
   endtask

endmodule

/* File: bench/testbench.sv */
// Self-checking testbench for the priority mask and running priority block.
`timescale 1ns/1ps
`define CHECK(nm, e, g) check_val(nm, 64'(e), 64'(g))
module testbench
   import cpm_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] cfg = 12'he00;
   logic pend_valid = 1'b0;
   logic [7:0] pend_priority = 8'h00;
   logic active_valid = 1'b0;
   logic [7:0] active_priority = 8'h00;
   logic [7:0] vrp = 8'h5a;
   logic req_valid, req_write;
   logic [1:0] req_el, req_op0;
   logic [2:0] req_op1, req_op2;
   logic [3:0] req_crn, req_crm;
   logic [DATA_W-1:0] req_wdata, resp_rdata, r_rd;
   logic resp_valid, irq_forward, fwd4;
   cpm_result_t resp_result, r_res, res4;
   logic [1:0] resp_target_el, r_tgt;
   logic [CLASS_W-1:0] resp_class, r_cls;
   logic [7:0] priority_mask, virtual_priority_mask, mask4;
   int failures = 0;
   int cmp_count = 0;

   always #5 clk = ~clk;

   // ****************************************************************
   // Design instances and core model.
   // ****************************************************************
   cpm_cpu_prio #(.PRIO_BITS(8)) i_dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_write(req_write), .req_el(req_el), .req_op0(req_op0), .req_op1(req_op1), .req_crn(req_crn),
      .req_crm(req_crm), .req_op2(req_op2), .req_wdata(req_wdata), .sre_el1(cfg[11]), .sre_el2(cfg[10]),
      .sre_el3(cfg[9]), .el2_enabled(cfg[8]), .el3_present(cfg[7]), .common_reg_trap(cfg[6]),
      .fiq_route_override(cfg[5]), .irq_route_override(cfg[4]), .secure_irq_route(cfg[3]),
      .secure_fiq_route(cfg[2]), .halted(cfg[1]), .secure_debug_disable(cfg[0]), .pend_valid(pend_valid),
      .pend_priority(pend_priority), .active_valid(active_valid), .active_priority(active_priority),
      .virtual_running_priority(vrp), .resp_valid(resp_valid), .resp_result(resp_result),
      .resp_target_el(resp_target_el), .resp_class(resp_class), .resp_rdata(resp_rdata),
      .irq_forward(irq_forward), .priority_mask(priority_mask), .virtual_priority_mask(virtual_priority_mask));
   cpm_cpu_prio #(.PRIO_BITS(4), .EL3_TRAP_PRIO(1'b0)) i_dut4 (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_write(req_write), .req_el(req_el), .req_op0(req_op0), .req_op1(req_op1), .req_crn(req_crn),
      .req_crm(req_crm), .req_op2(req_op2), .req_wdata(req_wdata), .sre_el1(cfg[11]), .sre_el2(cfg[10]),
      .sre_el3(cfg[9]), .el2_enabled(cfg[8]), .el3_present(cfg[7]), .common_reg_trap(cfg[6]),
      .fiq_route_override(cfg[5]), .irq_route_override(cfg[4]), .secure_irq_route(cfg[3]),
      .secure_fiq_route(cfg[2]), .halted(cfg[1]), .secure_debug_disable(cfg[0]), .pend_valid(pend_valid),
      .pend_priority(pend_priority), .active_valid(active_valid), .active_priority(active_priority),
      .virtual_running_priority(vrp), .resp_valid(), .resp_result(res4), .resp_target_el(), .resp_class(),
      .resp_rdata(), .irq_forward(fwd4), .priority_mask(mask4), .virtual_priority_mask());
   cpm_core_model i_core (.clk(clk), .resp_valid(resp_valid), .resp_result(resp_result),
      .resp_target_el(resp_target_el), .resp_class(resp_class), .resp_rdata(resp_rdata),
      .req_valid(req_valid), .req_write(req_write), .req_el(req_el), .req_op0(req_op0), .req_op1(req_op1),
      .req_crn(req_crn), .req_crm(req_crm), .req_op2(req_op2), .req_wdata(req_wdata));

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic check_val(input string nm, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic acc(input logic wr, input logic [1:0] el, input logic [3:0] crn, input logic [3:0] crm,
                      input logic [2:0] op2, input logic [63:0] wd);
      i_core.access(wr, el, crn, crm, op2, wd, r_res, r_tgt, r_cls, r_rd);
   endtask

   task automatic wr_mask(input logic [1:0] el, input logic [63:0] wd);
      acc(1'b1, el, PMR_CRN, PMR_CRM, PMR_OP2, wd);
   endtask

   task automatic rd_mask(input logic [1:0] el);
      acc(1'b0, el, PMR_CRN, PMR_CRM, PMR_OP2, 64'h0000_0000_0000_0000);
   endtask

   task automatic rd_run(input logic [1:0] el);
      acc(1'b0, el, RPR_CRN, RPR_CRM, RPR_OP2, 64'h0000_0000_0000_0000);
   endtask

   task automatic set_irq(input logic pv, input logic [7:0] pp, input logic av, input logic [7:0] ap);
      @(posedge clk);
      pend_valid <= pv;
      pend_priority <= pp;
      active_valid <= av;
      active_priority <= ap;
      @(posedge clk);
      #1;
   endtask

   task automatic dec(input logic [1:0] el, input logic [11:0] c, input cpm_result_t er, input logic [1:0] et);
      @(posedge clk);
      cfg <= c;
      rd_mask(el);
      `CHECK("result", er, r_res);
      `CHECK("target", et, r_tgt);
      `CHECK("class", (er == CPM_RES_TRAP) ? TRAP_CLASS : NO_CLASS, r_cls);
   endtask

   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHECK("mask after reset", 8'h00, priority_mask);
      rd_run(LVL_EL1);
      `CHECK("idle running", 8'hff, r_rd);
      `CHECK("response valid", 1'b1, resp_valid);
      $display("test reset done");
      set_irq(1'b1, 8'h7f, 1'b0, 8'h00);
      `CHECK("forward at zero mask", 1'b0, irq_forward);
      wr_mask(LVL_EL1, 64'hffff_ffff_ffff_ff80);
      `CHECK("forward after write", 1'b1, irq_forward);
      `CHECK("mask", 8'h80, priority_mask);
      rd_mask(LVL_EL3);
      `CHECK("mask read", 8'h80, r_rd);
      set_irq(1'b1, 8'h80, 1'b0, 8'h00);
      `CHECK("equal priority", 1'b0, irq_forward);
      wr_mask(LVL_EL3, 64'h0000_0000_0000_008f);
      `CHECK("coarse mask", 8'h80, mask4);
      set_irq(1'b1, 8'h8e, 1'b0, 8'h00);
      `CHECK("fine forward", 1'b1, irq_forward);
      `CHECK("coarse forward", 1'b0, fwd4);
      $display("test mask done");
      set_irq(1'b0, 8'h00, 1'b1, 8'h43);
      rd_run(LVL_EL1);
      `CHECK("running", 8'h42, r_rd);
      acc(1'b1, LVL_EL1, RPR_CRN, RPR_CRM, RPR_OP2, 64'h0000_0000_0000_0011);
      `CHECK("running write", CPM_RES_UNDEF, r_res);
      acc(1'b0, LVL_EL1, 4'h5, PMR_CRM, PMR_OP2, 64'h0000_0000_0000_0000);
      `CHECK("unknown encoding", CPM_RES_UNDEF, r_res);
      $display("test running done");
      @(posedge clk);
      cfg <= 12'hf20;
      wr_mask(LVL_EL1, 64'h0000_0000_0000_0040);
      `CHECK("virtual result", CPM_RES_VIRT, r_res);
      `CHECK("virtual mask", 8'h40, virtual_priority_mask);
      `CHECK("physical kept", 8'h8f, priority_mask);
      rd_run(LVL_EL1);
      `CHECK("virtual running", 8'h5a, r_rd);
      $display("test virtual done");
      dec(LVL_EL0, 12'he00, CPM_RES_UNDEF, LVL_EL0);
      dec(LVL_EL1, 12'h600, CPM_RES_TRAP, LVL_EL1);
      dec(LVL_EL1, 12'hf40, CPM_RES_TRAP, LVL_EL2);
      dec(LVL_EL1, 12'hf10, CPM_RES_VIRT, LVL_EL1);
      dec(LVL_EL1, 12'he10, CPM_RES_PHYS, LVL_EL1);
      dec(LVL_EL1, 12'he8c, CPM_RES_TRAP, LVL_EL3);
      dec(LVL_EL1, 12'he88, CPM_RES_PHYS, LVL_EL1);
      dec(LVL_EL1, 12'he8f, CPM_RES_UNDEF, LVL_EL1);
      `CHECK("late undef", CPM_RES_UNDEF, res4);
      dec(LVL_EL1, 12'h68f, CPM_RES_UNDEF, LVL_EL1);
      `CHECK("trap before undef", CPM_RES_TRAP, res4);
      dec(LVL_EL2, 12'ha00, CPM_RES_TRAP, LVL_EL2);
      dec(LVL_EL2, 12'he8c, CPM_RES_TRAP, LVL_EL3);
      dec(LVL_EL2, 12'hf30, CPM_RES_PHYS, LVL_EL2);
      dec(LVL_EL3, 12'hc00, CPM_RES_TRAP, LVL_EL3);
      dec(LVL_EL3, 12'he8c, CPM_RES_PHYS, LVL_EL3);
      $display("test access checks done");
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHECK("mask warm reset", 8'h00, priority_mask);
      `CHECK("virtual warm reset", 8'h00, virtual_priority_mask);
      `CHECK("forward warm reset", 1'b0, irq_forward);
      rd_mask(LVL_EL3);
      `CHECK("mask read after reset", 8'h00, r_rd);
      $display("test warm reset done");
      print_verdict();
   end

   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      print_verdict();
   end

endmodule
